// [verilog/logic_engine_pkg.sv]
// Package for the postfix logic equation engine.
// Assumes a single 40 MHz clock domain and one engine instance.
package logic_engine_pkg;
  localparam int ENTRY_COUNT = 512;
  localparam int ADDR_W = 9;
  localparam int ARG_W = 8;
  localparam int OPERAND_COUNT = 256;
  localparam int SOFT_COUNT = 64;
  localparam int TIMER_COUNT = 32;
  localparam int ONESHOT_MAX = 32;
  localparam int LATCH_MAX = 32;
  localparam int STACK_DEPTH = 32;
  localparam int SP_W = 6;
  localparam int SLOT_W = 6;
  localparam logic [ARG_W-1:0] GATE_MIN = 8'h02;
  localparam logic [ARG_W-1:0] GATE_MAX = 8'h10;
  localparam logic [SP_W-1:0] STACK_FULL = 6'h20;

  typedef enum logic [3:0] {
    OP_END = 4'h0,
    OP_OPERAND = 4'h1,
    OP_SOFT = 4'h2,
    OP_NOT = 4'h3,
    OP_OR = 4'h4,
    OP_AND = 4'h5,
    OP_NOR = 4'h6,
    OP_NAND = 4'h7,
    OP_XOR = 4'h8,
    OP_LATCH = 4'h9,
    OP_POS_SHOT = 4'ha,
    OP_NEG_SHOT = 4'hb,
    OP_DUAL_SHOT = 4'hc,
    OP_TIMER = 4'hd,
    OP_ASSIGN = 4'he
  } opcode_t;

  typedef struct packed {
    opcode_t op;
    logic [ARG_W-1:0] arg;
  } entry_t;

  typedef enum logic [1:0] {
    EDIT_WRITE = 2'h0,
    EDIT_INSERT = 2'h1,
    EDIT_DELETE = 2'h2
  } edit_kind_t;

  typedef struct packed {
    edit_kind_t kind;
    logic [ADDR_W-1:0] addr;
    entry_t entry;
  } edit_cmd_t;

  typedef enum logic [1:0] {
    ST_CLEAR = 2'h0,
    ST_RUN = 2'h1,
    ST_INSERT = 2'h2,
    ST_DELETE = 2'h3
  } state_t;

  localparam entry_t END_ENTRY = '{op: OP_END, arg: 8'h00};
endpackage

// [verilog/logic_engine.sv]
// Postfix logic equation engine: list store, editor and evaluator.
// Assumes operand, enable and timer inputs are synchronous to ref_clk;
// timers themselves live outside and only see start levels from here.
module logic_engine #(
  parameter int ENTRIES = logic_engine_pkg::ENTRY_COUNT
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic edit_valid,
  output logic edit_ready,
  input wire logic_engine_pkg::edit_cmd_t edit_cmd,
  input wire logic [logic_engine_pkg::OPERAND_COUNT-1:0] operand_state,
  input wire logic [logic_engine_pkg::OPERAND_COUNT-1:0] operand_enable,
  input wire logic [logic_engine_pkg::TIMER_COUNT-1:0] timer_out,
  output logic [logic_engine_pkg::TIMER_COUNT-1:0] timer_start,
  output logic [logic_engine_pkg::SOFT_COUNT-1:0] soft_output,
  output logic syntax_err,
  output logic pass_done
);
  import logic_engine_pkg::*;

  localparam logic [ADDR_W-1:0] LAST = ADDR_W'(ENTRIES - 1);

  function automatic logic gate_eval(input opcode_t op,
                                     input logic [STACK_DEPTH-1:0] stk,
                                     input logic [4:0] n);
    logic [STACK_DEPTH-1:0] mask;
    logic any_one;
    logic all_one;
    mask = ~({STACK_DEPTH{1'b1}} << n);
    any_one = |(stk & mask);
    all_one = &(stk | ~mask);
    case (op)
      OP_OR: gate_eval = any_one;
      OP_AND: gate_eval = all_one;
      OP_NOR: gate_eval = ~any_one;
      OP_NAND: gate_eval = ~all_one;
      default: gate_eval = 1'b0;
    endcase
  endfunction

  entry_t mem_q [ENTRIES];
  state_t state_q;
  logic [ADDR_W-1:0] ptr_q;
  edit_cmd_t edit_q;

  logic [ADDR_W-1:0] pc_q;
  logic [STACK_DEPTH-1:0] stk_q;
  logic [SP_W-1:0] sp_q;
  logic bad_q;
  logic [SLOT_W-1:0] os_idx_q;
  logic [SLOT_W-1:0] lt_idx_q;
  logic [ONESHOT_MAX-1:0] os_prev_q;
  logic [LATCH_MAX-1:0] latch_q;
  logic [TIMER_COUNT-1:0] tmr_used_q;
  logic [SOFT_COUNT-1:0] soft_used_q;
  logic [SOFT_COUNT-1:0] soft_out_q;
  logic [TIMER_COUNT-1:0] timer_start_q;
  logic syntax_err_q;
  logic pass_done_q;

  // Editor: list storage and shifting.
  wire logic accept = ce && (state_q == ST_RUN) && edit_valid;
  wire logic ins_end = (state_q == ST_INSERT) && (ptr_q == edit_q.addr);
  wire logic del_end = (state_q == ST_DELETE) && (ptr_q == LAST);
  wire logic recompile = (accept && edit_cmd.kind == EDIT_WRITE) ||
                         (ce && (ins_end || del_end));
  wire logic run = ce && (state_q == ST_RUN) && !recompile;

  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  entry_t mem_wd;
  always_comb begin
    mem_we = ce;
    mem_wa = ptr_q;
    mem_wd = END_ENTRY;
    case (state_q)
      ST_CLEAR: mem_wd = END_ENTRY;
      ST_RUN: begin
        mem_we = accept && (edit_cmd.kind == EDIT_WRITE);
        mem_wa = edit_cmd.addr;
        mem_wd = edit_cmd.entry;
      end
      ST_INSERT: mem_wd = ins_end ? edit_q.entry : mem_q[ptr_q - 1'b1];
      ST_DELETE: mem_wd = del_end ? END_ENTRY : mem_q[ptr_q + 1'b1];
      default: mem_we = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q <= ST_CLEAR;
      ptr_q <= '0;
      edit_q <= '0;
    end else if (ce) begin
      case (state_q)
        ST_CLEAR: begin
          ptr_q <= ptr_q + 1'b1;
          if (ptr_q == LAST) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          edit_q <= edit_cmd;
          if (accept && edit_cmd.kind == EDIT_INSERT) begin
            state_q <= ST_INSERT;
            ptr_q <= LAST;
          end else if (accept && edit_cmd.kind == EDIT_DELETE) begin
            state_q <= ST_DELETE;
            ptr_q <= edit_cmd.addr;
          end
        end
        ST_INSERT: begin
          ptr_q <= ptr_q - 1'b1;
          if (ins_end) begin
            state_q <= ST_RUN;
          end
        end
        ST_DELETE: begin
          ptr_q <= ptr_q + 1'b1;
          if (del_end) begin
            state_q <= ST_RUN;
          end
        end
        default: state_q <= ST_CLEAR;
      endcase
    end
  end

  // Evaluator: decode of the entry under the program counter.
  wire entry_t cur = mem_q[pc_q];
  wire logic [4:0] arg5 = cur.arg[4:0];
  wire logic [5:0] arg6 = cur.arg[5:0];
  wire logic [4:0] os_slot = os_idx_q[4:0];
  wire logic [4:0] lt_slot = lt_idx_q[4:0];
  wire logic os_prev = os_prev_q[os_slot];
  wire logic latch_next = ~stk_q[0] & (stk_q[1] | latch_q[lt_slot]);
  wire logic is_end = (cur.op == OP_END);
  wire logic pass_end = is_end || (pc_q == LAST);

  logic [SP_W-1:0] need;
  logic res;
  logic push;
  logic err;
  always_comb begin
    need = '0;
    res = 1'b0;
    push = 1'b1;
    err = 1'b0;
    case (cur.op)
      OP_OPERAND: begin
        res = operand_state[cur.arg] & operand_enable[cur.arg];
      end
      OP_SOFT: begin
        err = (cur.arg >= ARG_W'(SOFT_COUNT));
        res = soft_out_q[arg6];
      end
      OP_NOT: begin
        need = 6'h01;
        res = ~stk_q[0];
      end
      OP_OR, OP_AND, OP_NOR, OP_NAND: begin
        need = {1'b0, arg5};
        err = (cur.arg < GATE_MIN) || (cur.arg > GATE_MAX);
        res = gate_eval(cur.op, stk_q, arg5);
      end
      OP_XOR: begin
        need = 6'h02;
        res = stk_q[0] ^ stk_q[1];
      end
      OP_LATCH: begin
        need = 6'h02;
        err = (lt_idx_q >= SLOT_W'(LATCH_MAX));
        res = latch_next;
      end
      OP_POS_SHOT, OP_NEG_SHOT, OP_DUAL_SHOT: begin
        need = 6'h01;
        err = (os_idx_q >= SLOT_W'(ONESHOT_MAX));
        case (cur.op)
          OP_POS_SHOT: res = stk_q[0] & ~os_prev;
          OP_NEG_SHOT: res = ~stk_q[0] & os_prev;
          default: res = stk_q[0] ^ os_prev;
        endcase
      end
      OP_TIMER: begin
        need = 6'h01;
        err = (cur.arg >= ARG_W'(TIMER_COUNT)) || tmr_used_q[arg5];
        res = timer_out[arg5];
      end
      OP_ASSIGN: begin
        need = 6'h01;
        push = 1'b0;
        err = (cur.arg >= ARG_W'(SOFT_COUNT)) || soft_used_q[arg6];
      end
      default: begin
        push = 1'b0;
      end
    endcase
  end

  // A short stack gives up its remaining items rather than wrapping.
  wire logic under = (sp_q < need);
  wire logic [SP_W-1:0] pops = under ? sp_q : need;
  wire logic [STACK_DEPTH-1:0] popped = stk_q >> pops;
  wire logic [SP_W-1:0] sp_pop = sp_q - pops;
  wire logic over = push && (sp_pop == STACK_FULL);
  wire logic fault = !is_end && (err || under || over);
  wire logic ok = !is_end && !fault;
  wire logic do_assign = ok && !bad_q && (cur.op == OP_ASSIGN);
  wire logic is_shot = (cur.op == OP_POS_SHOT) ||
                       (cur.op == OP_NEG_SHOT) ||
                       (cur.op == OP_DUAL_SHOT);
  wire logic tmr_arg_ok = (cur.arg < ARG_W'(TIMER_COUNT));
  wire logic soft_arg_ok = (cur.arg < ARG_W'(SOFT_COUNT));

  always_ff @(posedge ref_clk) begin
    if (!reset_n || recompile) begin
      pc_q <= '0;
      stk_q <= '0;
      sp_q <= '0;
      bad_q <= 1'b0;
      os_idx_q <= '0;
      lt_idx_q <= '0;
      os_prev_q <= '0;
      latch_q <= '0;
      tmr_used_q <= '0;
      soft_used_q <= '0;
      pass_done_q <= 1'b0;
    end else if (run) begin
      pass_done_q <= pass_end;
      if (pass_end) begin
        pc_q <= '0;
        stk_q <= '0;
        sp_q <= '0;
        bad_q <= 1'b0;
        os_idx_q <= '0;
        lt_idx_q <= '0;
        tmr_used_q <= '0;
        soft_used_q <= '0;
      end else begin
        pc_q <= pc_q + 1'b1;
        if (cur.op == OP_ASSIGN) begin
          sp_q <= '0;
          stk_q <= '0;
          bad_q <= 1'b0;
        end else begin
          sp_q <= (over || !push) ? sp_pop : sp_pop + 1'b1;
          stk_q <= push ? {popped[STACK_DEPTH-2:0], res} : popped;
          bad_q <= bad_q | fault;
        end
      end
      if (ok && cur.op == OP_LATCH) begin
        latch_q[lt_slot] <= latch_next;
      end
      // Bookkeeping skips the closing step, else it would leak into the
      // next pass; slot counts saturate so an overfull list stays flagged.
      if (!pass_end && cur.op == OP_LATCH && !lt_idx_q[5]) begin
        lt_idx_q <= lt_idx_q + 1'b1;
      end
      // The stored input ends a one-shot pulse on the following pass.
      if (ok && is_shot) begin
        os_prev_q[os_slot] <= stk_q[0];
      end
      if (!pass_end && is_shot && !os_idx_q[5]) begin
        os_idx_q <= os_idx_q + 1'b1;
      end
      if (!pass_end && cur.op == OP_TIMER && tmr_arg_ok) begin
        tmr_used_q[arg5] <= 1'b1;
      end
      if (!pass_end && cur.op == OP_ASSIGN && soft_arg_ok) begin
        soft_used_q[arg6] <= 1'b1;
      end
    end else if (ce) begin
      pass_done_q <= 1'b0;
    end
  end

  // Timer starts and soft outputs survive an edit; latches and one-shot history clear.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      soft_out_q <= '0;
      timer_start_q <= '0;
      syntax_err_q <= 1'b0;
    end else if (ce) begin
      if (run && ok && cur.op == OP_TIMER) begin
        timer_start_q[arg5] <= stk_q[0];
      end
      if (run && do_assign) begin
        soft_out_q[arg6] <= stk_q[0];
      end
      syntax_err_q <= (syntax_err_q && !recompile) || (run && fault);
    end
  end

  assign edit_ready = (state_q == ST_RUN);
  assign timer_start = timer_start_q;
  assign soft_output = soft_out_q;
  assign syntax_err = syntax_err_q;
  assign pass_done = pass_done_q;
endmodule

// [bench/logic_engine_props.sv]
// Port assertions for the logic engine, attached by bind.
// Assumes ce stays high, so shift and pass lengths count clocks.
module logic_engine_props #(
  parameter int ENTRIES = logic_engine_pkg::ENTRY_COUNT
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic edit_valid,
  input wire logic edit_ready,
  input wire logic_engine_pkg::edit_cmd_t edit_cmd,
  input wire logic [logic_engine_pkg::TIMER_COUNT-1:0] timer_start,
  input wire logic [logic_engine_pkg::SOFT_COUNT-1:0] soft_output,
  input wire logic syntax_err,
  input wire logic pass_done
);
  import logic_engine_pkg::*;
  localparam int SHIFT_MAX = ENTRIES;
  localparam int PASS_MAX = ENTRIES + 8;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  wire take = ce && edit_valid && edit_ready;
  wire wr_take = take && edit_cmd.kind == EDIT_WRITE;
  wire sh_take = take && (edit_cmd.kind == EDIT_INSERT ||
                          edit_cmd.kind == EDIT_DELETE);
  sequence shift_s;
    !edit_ready ##[1:SHIFT_MAX] edit_ready;
  endsequence
  // A later edit also discharges the wait, since it restarts the pass.
  sequence restart_s;
    ##[1:PASS_MAX] (pass_done || take);
  endsequence
  a_clear_holds_ready: assert property (
    $rose(reset_n) |-> !edit_ready[*8])
    else $error("ready during clear");
  a_reset_clears_out: assert property ($rose(reset_n) |->
    soft_output == '0 && timer_start == '0 && !syntax_err && !pass_done)
    else $error("outputs not cleared");
  a_write_keeps_ready: assert property (wr_take |=> edit_ready)
    else $error("write dropped ready");
  a_shift_ends: assert property (sh_take |=> shift_s)
    else $error("shift length wrong");
  a_edit_clears_err: assert property (wr_take |=> !syntax_err)
    else $error("error kept after edit");
  // The end of a shift recompiles and clears the flag, so only run counts.
  a_err_sticky: assert property (
    syntax_err && edit_ready && !take |=> syntax_err)
    else $error("error flag lost");
  a_pass_restarts: assert property (wr_take |-> restart_s)
    else $error("no pass after edit");
  a_shift_freezes: assert property (!edit_ready[*2] |=>
    $stable(soft_output) && $stable(timer_start))
    else $error("outputs moved while busy");
endmodule

bind logic_engine logic_engine_props #(.ENTRIES(ENTRIES))
  u_logic_engine_props (
  .ref_clk, .reset_n, .ce, .edit_valid, .edit_ready, .edit_cmd,
  .timer_start, .soft_output, .syntax_err, .pass_done);

// [bench/timer_bank.sv]
// Model of the external timer bank with one clock of pickup delay.
// Assumes the engine's start levels are synchronous to ref_clk.
module timer_bank (
  input wire logic ref_clk,
  input wire logic [31:0] start,
  output logic [31:0] out
);
  timeunit 1ns;
  timeprecision 100ps;
  // One register stage stands for the timer, so results lag one clock.
  always @(posedge ref_clk) out <= start;
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the logic engine.
// Assumes the timer model answers in place of the real timers.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import logic_engine_pkg::*;
  logic ref_clk = 0, reset_n = 0, ce = 1, edit_valid = 0, edit_ready;
  edit_cmd_t edit_cmd = '0;
  logic [255:0] op_st = '0, op_en = '1;
  logic [31:0] t_out, t_start;
  logic [63:0] so;
  logic err, done;
  int miscompares = 0, total_checks = 0;
  logic_engine u_logic_engine (.ref_clk, .reset_n, .ce, .edit_valid,
    .edit_ready, .edit_cmd, .operand_state(op_st), .operand_enable(op_en),
    .timer_out(t_out), .timer_start(t_start), .soft_output(so),
    .syntax_err(err), .pass_done(done));
  timer_bank u_timer_bank (.ref_clk, .start(t_start), .out(t_out));
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic chk(logic [63:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h not %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Every polling wait in ed and passes steps through here so that a hang ends the run.
  task automatic tick(inout int n);
    @(negedge ref_clk);
    if (++n > 20000) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic ed(int a, opcode_t o, int g, edit_kind_t k = EDIT_WRITE);
    int n = 0;
    @(posedge ref_clk);
    edit_cmd <= '{k, a[8:0], '{o, g[7:0]}};
    edit_valid <= 1;
    do tick(n); while (edit_ready !== 1'b1);
    @(posedge ref_clk);
    edit_valid <= 0;
  endtask
  task automatic passes(int p);
    int n = 0;
    while (p > 0) begin
      tick(n);
      if (done === 1'b1) p--;
    end
  endtask
  // Writes run from the last entry back, so no half equation is live.
  task automatic load(int b, opcode_t o[$], int g[$]);
    for (int i = o.size() - 1; i >= 0; i--) ed(b + i, o[i], g[i]);
  endtask
  task automatic drv(logic [3:0] v, logic en0 = 1);
    @(posedge ref_clk);
    op_st[3:0] <= v;
    op_en[0] <= en0;
  endtask
  task automatic gates();
    opcode_t g[5] = '{OP_AND, OP_OR, OP_NOR, OP_NAND, OP_XOR};
    logic a, b;
    logic [7:0] e;
    foreach (g[i]) begin
      load(4 * i, '{OP_OPERAND, OP_OPERAND, g[i], OP_ASSIGN}, '{0, 1, 2, i});
    end
    load(20, '{OP_OPERAND, OP_NOT, OP_ASSIGN}, '{0, 0, 5});
    for (int i = 23; i < 39; i++) ed(i, OP_OPERAND, 3);
    load(39, '{OP_NOR, OP_ASSIGN}, '{16, 7});
    load(100, '{OP_OPERAND, OP_ASSIGN}, '{1, 6});
    for (int i = 0; i < 5; i++) begin
      a = i[0];
      b = i[1];
      drv({a, 1'b0, b, i[0] | i[2]}, !i[2]);
      passes(2);
      e = {~a, 1'b0, ~a, a ^ b, ~(a & b), ~(a | b), a | b, a & b};
      chk(so[7:0], e);
    end
  endtask
  task automatic shots(logic a, logic [15:0] e);
    logic [3:0] c [4] = '{default: '0};
    drv({3'b000, a});
    repeat (4) begin
      passes(1);
      c[0] += so[9];
      c[1] += so[10];
      c[2] += so[11];
      c[3] += so[12] & !so[13];
    end
    chk({c[0], c[1], c[2], c[3]}, e);
  endtask
  task automatic latch();
    logic [2:0] s [6] = '{3'b101, 3'b001, 3'b110, 3'b000, 3'b101, 3'b001};
    load(41, '{OP_OPERAND, OP_OPERAND, OP_LATCH, OP_ASSIGN, OP_OPERAND,
      OP_POS_SHOT, OP_ASSIGN, OP_OPERAND, OP_NEG_SHOT, OP_ASSIGN, OP_OPERAND,
      OP_DUAL_SHOT, OP_ASSIGN, OP_SOFT, OP_ASSIGN, OP_OPERAND, OP_ASSIGN},
      '{0, 1, 0, 8, 0, 0, 9, 0, 0, 10, 0, 0, 11, 12, 13, 0, 12});
    foreach (s[i]) begin
      drv({2'b00, s[i][1], s[i][2]});
      passes(2);
      chk(so[8], s[i][0]);
    end
    drv(4'h0);
    ed(41, OP_OPERAND, 0);
    passes(2);
    chk(so[8], 0);
    shots(1, 16'h1011);
    shots(0, 16'h0110);
  endtask
  task automatic faults();
    drv(4'h0);
    load(58, '{OP_OPERAND, OP_ASSIGN}, '{1, 12});
    passes(2);
    chk(err, 1);
    ed(59, OP_ASSIGN, 14);
    passes(2);
    chk({err, so[14]}, 0);
    ed(58, OP_NOT, 0);
    passes(2);
    chk({err, so[14]}, 2'b10);
    drv(4'h2);
    load(58, '{OP_OPERAND, OP_AND, OP_ASSIGN}, '{1, 1, 14});
    passes(2);
    chk({err, so[14]}, 2'b10);
  endtask
  task automatic edits();
    @(posedge ref_clk);
    reset_n <= 0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1;
    passes(2);
    chk(so, 0);
    drv(4'h1);
    load(0, '{OP_OPERAND, OP_ASSIGN, OP_OPERAND, OP_TIMER, OP_ASSIGN},
      '{0, 15, 0, 5, 16});
    ed(1, OP_NOT, 0, EDIT_INSERT);
    passes(2);
    chk({t_start[5], so[16:15]}, 3'b110);
    ed(1, OP_END, 0, EDIT_DELETE);
    passes(2);
    chk(so[16:15], 2'b11);
    load(5, '{OP_OPERAND, OP_TIMER, OP_ASSIGN}, '{0, 5, 17});
    passes(2);
    chk({err, so[17]}, 2'b10);
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1;
    gates();
    latch();
    faults();
    edits();
    test_done();
  end
endmodule
